// [hw/dscp_defines.svh]
// Offsets, field positions, reset values and timing for the config bank.
// Assumes a 125 MHz core clock; included by its bare name.
`ifndef DSCP_DEFINES_SVH
`define DSCP_DEFINES_SVH

`define DSCP_ADDR_W           15
`define DSCP_OFF_INTF_CFG     15'h0000
`define DSCP_OFF_CHIP_CAT     15'h0003
`define DSCP_OFF_PROD_LO      15'h0003
`define DSCP_OFF_PROD_HI      15'h0004
`define DSCP_OFF_GRADE_REV    15'h0005
`define DSCP_OFF_LINK_PAGE    15'h0008
`define DSCP_OFF_PWR_MAIN     15'h0011

`define DSCP_CFG_REINIT       0
`define DSCP_CFG_LOW_BIT_ORD  1
`define DSCP_CFG_ADDR_UP      2
`define DSCP_CFG_OUT_DRIVE    3

`define DSCP_PWR_REF_OFF      7
`define DSCP_PWR_CHAN0_OFF    6
`define DSCP_PWR_CHAN1_OFF    5
`define DSCP_PWR_CHAN2_OFF    4
`define DSCP_PWR_CHAN3_OFF    3

`define DSCP_RST_INTF_CFG     4'h0
`define DSCP_RST_LINK_PAGE    2'h3
`define DSCP_RST_PWR_MAIN     5'h1f

`define DSCP_INSTR_BITS       4'hf
`define DSCP_BYTE_BITS        4'h7
`define DSCP_RD_FLAG          14

`define DSCP_CLK_PERIOD_NS    8
`define DSCP_SOFT_RESET_NS    128
`define DSCP_SOFT_RESET_CYC   ((`DSCP_SOFT_RESET_NS + `DSCP_CLK_PERIOD_NS \
	- 1) / `DSCP_CLK_PERIOD_NS)

`endif

// [hw/dscp_pkg.sv]
// Types shared by the config bank.
// Assumes nothing beyond a SystemVerilog compiler.
package dscp_pkg;
	typedef enum logic [2:0] {
		DSCP_IDLE  = 3'b001,
		DSCP_INSTR = 3'b010,
		DSCP_DATA  = 3'b100
	} dscp_state_t;
endpackage : dscp_pkg

// [hw/dscp_sync.sv]
// Two-flop synchroniser for a group of asynchronous pins.
// Assumes the pins are independent levels; no bus coherence is kept.
`timescale 1ns/1ns
module dscp_sync #(
	parameter int               WIDTH   = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input  wire logic             clock,
	input  wire logic             rst_b,
	input  wire logic             ce,
	input  wire logic [WIDTH-1:0] asyncIn,
	output wire logic [WIDTH-1:0] syncOut
);
	logic [WIDTH-1:0] meta_r;
	logic [WIDTH-1:0] meta_nxt;
	logic [WIDTH-1:0] stable_r;
	logic [WIDTH-1:0] stable_nxt;

	always_comb begin
		meta_nxt   = ce ? asyncIn : meta_r;
		stable_nxt = ce ? meta_r : stable_r;
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			meta_r   <= RST_VAL;
			stable_r <= RST_VAL;
		end else begin
			meta_r   <= meta_nxt;
			stable_r <= stable_nxt;
		end
	end

	assign syncOut = stable_r;
endmodule : dscp_sync

// [hw/dscp_regbank.sv]
// Serial control port and low-address config, ID and power-down bank.
// Assumes serial pins, tx gate pins asynchronous; mask bits from core logic.
// Overview of operation
// - Bit-order bit 1 set shifts data low bit first, clear high bit first.
// - Writing 1 to config bit 0 starts an internal soft reset.
// - The soft reset bit clears itself when the soft reset has finished.
// - The link page pointer is a two-bit field in bits 1:0 that resets to 3.
// - Paged writes go to link A for page 1, B for page 2, both for page 3.
// - Bit 7 resets to 1 and holds the reference off; the tx gates do not act on it.
// - Bit 6 powers down channel 0 when set, overriding gating, reset value 1.
// - Bit 5 powers down channel 1 when set, overriding gating, reset value 1.
// - Bit 4 powers down channel 2 when set, overriding gating, reset value 1.
// - Bit 3 powers down channel 3 when set, overriding gating, reset value 1.
// - With the dual A mask set and tx gate A low, channels 0 and 1 are off.
// - With the dual B mask set and tx gate B low, channels 2 and 3 are off.
`timescale 1ns/1ns
`include "dscp_defines.svh"
module dscp_regbank #(
	parameter logic [7:0] CHIP_CATEGORY = 8'h5a, // Arbitrary value
	parameter logic [7:0] PRODUCT_LO    = 8'h3c, // Arbitrary value
	parameter logic [7:0] PRODUCT_HI    = 8'hc3, // Arbitrary value
	parameter logic [3:0] PART_GRADE    = 4'h1,  // Arbitrary value
	parameter logic [3:0] SILICON_REV   = 4'h2   // Arbitrary value
) (
	input  wire logic        clock,
	input  wire logic        rst_b,
	input  wire logic        ce,
	input  wire logic        spiSelect_b,
	input  wire logic        spiSclk,
	input  wire logic        sdioIn,
	output wire logic        sdioOut,
	output wire logic        sdioOe_b,
	output wire logic        sdoOut,
	output wire logic        sdoOe_b,
	input  wire logic        txGateA,
	input  wire logic        txGateB,
	input  wire logic        dualAGateMask,
	input  wire logic        dualBGateMask,
	output wire logic        refOff,
	output wire logic [3:0]  chanOff,
	output wire logic        softResetOut,
	output wire logic        extWrStb,
	output wire logic [14:0] extAddr,
	output wire logic [7:0]  extData,
	output wire logic        extLinkA,
	output wire logic        extLinkB
);
	import dscp_pkg::*;

	logic [4:0]          pinSync;
	logic                csSync_b;
	logic                sclkSync;
	logic                sdiSync;
	logic                gateASync;
	logic                gateBSync;
	logic                sclkRise;
	dscp_state_t         state_r;
	dscp_state_t         state_nxt;
	logic [3:0]          bitCnt_r;
	logic [3:0]          bitCnt_nxt;
	logic [15:0]         shift_r;
	logic [15:0]         shift_nxt;
	logic                rdMode_r;
	logic                rdMode_nxt;
	logic [14:0]         addr_r;
	logic [14:0]         addr_nxt;
	logic [7:0]          txByte_r;
	logic [7:0]          txByte_nxt;
	logic                sclkDly_r;
	logic                sdioOut_r;
	logic                sdioOut_nxt;
	logic                sdioOe_b_r;
	logic                sdioOe_b_nxt;
	logic                sdoOut_r;
	logic                sdoOut_nxt;
	logic                sdoOe_b_r;
	logic                sdoOe_b_nxt;
	logic                wrEn;
	logic [14:0]         stepAddr;
	logic [7:0]          rxByte;
	logic                outBit;
	logic [3:0]          cfg_r;
	logic [3:0]          cfg_nxt;
	logic [1:0]          page_r;
	logic [1:0]          page_nxt;
	logic [7:3]          pwr_r;
	logic [7:3]          pwr_nxt;
	logic [7:0]          srCnt_r;
	logic [7:0]          srCnt_nxt;
	logic                self_clearing_reinit_r;
	logic                self_clearing_reinit_nxt;
	logic                refOff_r;
	logic                refOff_nxt;
	logic [3:0]          chanOff_r;
	logic [3:0]          chanOff_nxt;
	logic                extWrStb_r;
	logic                extWrStb_nxt;
	logic [14:0]         extAddr_r;
	logic [14:0]         extAddr_nxt;
	logic [7:0]          extData_r;
	logic [7:0]          extData_nxt;
	logic                extLinkA_r;
	logic                extLinkA_nxt;
	logic                extLinkB_r;
	logic                extLinkB_nxt;
	// Pins cross in; sclk edges found on the stable copy only
	dscp_sync #(
		.WIDTH  (5),
		.RST_VAL(5'h01) // Select idles high, no false frame after reset
	) uSync (
		.clock  (clock),
		.rst_b  (rst_b),
		.ce     (ce),
		.asyncIn({txGateB, txGateA, sdioIn, spiSclk, spiSelect_b}),
		.syncOut(pinSync)
	);
	assign csSync_b  = pinSync[0];
	assign sclkSync  = pinSync[1];
	assign sdiSync   = pinSync[2];
	assign gateASync = pinSync[3];
	assign gateBSync = pinSync[4];
	assign sclkRise  = sclkSync & ~sclkDly_r;
	function automatic logic [7:0] readReg(input logic [14:0] a);
		logic [7:0] v;
		v = 8'h00;
		case (a)
			`DSCP_OFF_INTF_CFG: v = {cfg_r[0], cfg_r[1], cfg_r[2], cfg_r[3],
				cfg_r};
			`DSCP_OFF_CHIP_CAT:  v = CHIP_CATEGORY;
			`DSCP_OFF_PROD_HI:   v = PRODUCT_HI;
			`DSCP_OFF_GRADE_REV: v = {PART_GRADE, SILICON_REV};
			`DSCP_OFF_LINK_PAGE: v = {6'h00, page_r};
			`DSCP_OFF_PWR_MAIN:  v = {pwr_r, 3'h0};
			default:             v = 8'h00;
		endcase
		return v;
	endfunction : readReg

	// Serial engine: 16-bit instruction high bit first, then data bytes
	always_comb begin
		state_nxt    = state_r;
		bitCnt_nxt   = bitCnt_r;
		shift_nxt    = shift_r;
		rdMode_nxt   = rdMode_r;
		addr_nxt     = addr_r;
		txByte_nxt   = txByte_r;
		sdioOut_nxt  = 1'b0;
		sdioOe_b_nxt = 1'b1;
		sdoOut_nxt   = 1'b0;
		sdoOe_b_nxt  = 1'b1;
		wrEn         = 1'b0;
		stepAddr     = cfg_r[`DSCP_CFG_ADDR_UP] ? 15'(addr_r + 15'h0001)
			: 15'(addr_r - 15'h0001);
		rxByte       = cfg_r[`DSCP_CFG_LOW_BIT_ORD]
			? {sdiSync, shift_r[7:1]} : {shift_r[6:0], sdiSync};
		outBit       = cfg_r[`DSCP_CFG_LOW_BIT_ORD] ? txByte_r[bitCnt_r[2:0]]
			: txByte_r[3'(3'h7 - bitCnt_r[2:0])];
		case (state_r)
			DSCP_IDLE: begin
				bitCnt_nxt = 4'h0;
				if (!csSync_b) begin
					state_nxt = DSCP_INSTR;
				end
			end
			DSCP_INSTR: begin
				if (sclkRise) begin
					shift_nxt  = {shift_r[14:0], sdiSync};
					bitCnt_nxt = 4'(bitCnt_r + 4'h1);
					if (bitCnt_r == `DSCP_INSTR_BITS) begin
						rdMode_nxt = shift_r[`DSCP_RD_FLAG];
						addr_nxt   = {shift_r[13:0], sdiSync};
						txByte_nxt = readReg({shift_r[13:0], sdiSync});
						bitCnt_nxt = 4'h0;
						state_nxt  = DSCP_DATA;
					end
				end
			end
			DSCP_DATA: begin
				if (rdMode_r) begin
					// Separate output line or shared data line
					if (cfg_r[`DSCP_CFG_OUT_DRIVE]) begin
						sdoOut_nxt  = outBit;
						sdoOe_b_nxt = 1'b0;
					end else begin
						sdioOut_nxt  = outBit;
						sdioOe_b_nxt = 1'b0;
					end
				end
				if (sclkRise) begin
					shift_nxt  = {shift_r[15:8], rxByte};
					bitCnt_nxt = 4'(bitCnt_r + 4'h1);
					if (bitCnt_r == `DSCP_BYTE_BITS) begin
						wrEn       = ~rdMode_r;
						addr_nxt   = stepAddr;
						txByte_nxt = readReg(stepAddr);
						bitCnt_nxt = 4'h0;
					end
				end
			end
			default: state_nxt = DSCP_IDLE;
		endcase
		// Select release aborts any partial byte
		if (csSync_b) begin
			state_nxt    = DSCP_IDLE;
			sdioOe_b_nxt = 1'b1;
			sdoOe_b_nxt  = 1'b1;
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			state_r    <= DSCP_IDLE;
			bitCnt_r   <= 4'h0;
			shift_r    <= 16'h0000;
			rdMode_r   <= 1'b0;
			addr_r     <= 15'h0000;
			txByte_r   <= 8'h00;
			sclkDly_r  <= 1'b0;
			sdioOut_r  <= 1'b0;
			sdioOe_b_r <= 1'b1;
			sdoOut_r   <= 1'b0;
			sdoOe_b_r  <= 1'b1;
		end else if (ce) begin
			state_r    <= state_nxt;
			bitCnt_r   <= bitCnt_nxt;
			shift_r    <= shift_nxt;
			rdMode_r   <= rdMode_nxt;
			addr_r     <= addr_nxt;
			txByte_r   <= txByte_nxt;
			sclkDly_r  <= sclkSync;
			sdioOut_r  <= sdioOut_nxt;
			sdioOe_b_r <= sdioOe_b_nxt;
			sdoOut_r   <= sdoOut_nxt;
			sdoOe_b_r  <= sdoOe_b_nxt;
		end
	end

	// Register bank, soft reset sequencer and power-down decode
	always_comb begin
		cfg_nxt       = cfg_r;
		page_nxt      = page_r;
		pwr_nxt       = pwr_r;
		srCnt_nxt     = srCnt_r;
		self_clearing_reinit_nxt = self_clearing_reinit_r;
		extWrStb_nxt  = 1'b0;
		extAddr_nxt   = extAddr_r;
		extData_nxt   = extData_r;
		extLinkA_nxt  = extLinkA_r;
		extLinkB_nxt  = extLinkB_r;
		if (wrEn) begin
			case (addr_r)
				`DSCP_OFF_INTF_CFG:
					cfg_nxt = {rxByte[3:1], cfg_r[0] | rxByte[0]};
				`DSCP_OFF_LINK_PAGE: page_nxt = rxByte[1:0];
				`DSCP_OFF_PWR_MAIN:  pwr_nxt = rxByte[7:3];
				`DSCP_OFF_CHIP_CAT, `DSCP_OFF_PROD_HI,
				`DSCP_OFF_GRADE_REV: cfg_nxt = cfg_r;
				default: begin
					extWrStb_nxt = 1'b1;
					extAddr_nxt  = addr_r;
					extData_nxt  = rxByte;
					extLinkA_nxt = page_r[0];
					extLinkB_nxt = page_r[1];
				end
			endcase
		end
		// Start restores bank defaults; bit 0 stays set while busy
		if (wrEn && addr_r == `DSCP_OFF_INTF_CFG && rxByte[0] && !self_clearing_reinit_r)
		begin
			self_clearing_reinit_nxt = 1'b1;
			srCnt_nxt     = 8'(`DSCP_SOFT_RESET_CYC);
			cfg_nxt       = `DSCP_RST_INTF_CFG | 4'h1;
			page_nxt      = `DSCP_RST_LINK_PAGE;
			pwr_nxt       = `DSCP_RST_PWR_MAIN;
		end else if (self_clearing_reinit_r) begin
			srCnt_nxt  = 8'(srCnt_r - 8'h01);
			cfg_nxt[0] = 1'b1;
			if (srCnt_r == 8'h01) begin
				self_clearing_reinit_nxt = 1'b0;
				cfg_nxt[0]    = 1'b0;
			end
		end
		refOff_nxt   = pwr_r[`DSCP_PWR_REF_OFF];
		chanOff_nxt[0] = pwr_r[`DSCP_PWR_CHAN0_OFF]
			| (dualAGateMask & ~gateASync);
		chanOff_nxt[1] = pwr_r[`DSCP_PWR_CHAN1_OFF]
			| (dualAGateMask & ~gateASync);
		chanOff_nxt[2] = pwr_r[`DSCP_PWR_CHAN2_OFF]
			| (dualBGateMask & ~gateBSync);
		chanOff_nxt[3] = pwr_r[`DSCP_PWR_CHAN3_OFF]
			| (dualBGateMask & ~gateBSync);
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			cfg_r       <= `DSCP_RST_INTF_CFG;
			page_r      <= `DSCP_RST_LINK_PAGE;
			pwr_r       <= `DSCP_RST_PWR_MAIN;
			srCnt_r     <= 8'h00;
			self_clearing_reinit_r <= 1'b0;
			refOff_r    <= 1'b1;
			chanOff_r   <= 4'hf;
			extWrStb_r  <= 1'b0;
			extAddr_r   <= 15'h0000;
			extData_r   <= 8'h00;
			extLinkA_r  <= 1'b0;
			extLinkB_r  <= 1'b0;
		end else if (ce) begin
			cfg_r       <= cfg_nxt;
			page_r      <= page_nxt;
			pwr_r       <= pwr_nxt;
			srCnt_r     <= srCnt_nxt;
			self_clearing_reinit_r <= self_clearing_reinit_nxt;
			refOff_r    <= refOff_nxt;
			chanOff_r   <= chanOff_nxt;
			extWrStb_r  <= extWrStb_nxt;
			extAddr_r   <= extAddr_nxt;
			extData_r   <= extData_nxt;
			extLinkA_r  <= extLinkA_nxt;
			extLinkB_r  <= extLinkB_nxt;
		end
	end

	assign sdioOut      = sdioOut_r;
	assign sdioOe_b     = sdioOe_b_r;
	assign sdoOut       = sdoOut_r;
	assign sdoOe_b      = sdoOe_b_r;
	assign refOff       = refOff_r;
	assign chanOff      = chanOff_r;
	assign softResetOut = self_clearing_reinit_r;
	assign extWrStb     = extWrStb_r;
	assign extAddr      = extAddr_r;
	assign extData      = extData_r;
	assign extLinkA     = extLinkA_r;
	assign extLinkB     = extLinkB_r;
endmodule : dscp_regbank

// [verif/dscp_regbank_props.sv]
// Pin-level checker for the config bank.
// Assumes ce held high; bound to dscp_regbank below.
`timescale 1ns/1ns
module dscp_regbank_props (
	input wire logic        clock,
	input wire logic        rst_b,
	input wire logic        spiSelect_b,
	input wire logic        sdioOe_b,
	input wire logic        sdoOe_b,
	input wire logic        txGateA,
	input wire logic        txGateB,
	input wire logic        dualAGateMask,
	input wire logic        dualBGateMask,
	input wire logic        refOff,
	input wire logic [3:0]  chanOff,
	input wire logic        softResetOut,
	input wire logic        extWrStb,
	input wire logic [14:0] extAddr,
	input wire logic [7:0]  extData,
	input wire logic        extLinkA,
	input wire logic        extLinkB
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);
	// Gate pins pass two sync flops and the chanOff flop, so five cycles of hold
	property p_gate_a;
		(dualAGateMask && !txGateA)[*5] |-> chanOff[1:0] == 2'b11;
	endproperty
	a_gate_a: assert property (p_gate_a) else $error("gate A");
	property p_gate_b;
		(dualBGateMask && !txGateB)[*5] |-> chanOff[3:2] == 2'b11;
	endproperty
	a_gate_b: assert property (p_gate_b) else $error("gate B");
	property p_rst_len;
		$rose(softResetOut) |-> softResetOut[*8] ##1 softResetOut[*8]
			##1 !softResetOut;
	endproperty
	a_rst_len: assert property (p_rst_len) else $error("reinit len");
	property p_rst_pwr;
		$rose(softResetOut) |=> refOff && chanOff == 4'hf;
	endproperty
	a_rst_pwr: assert property (p_rst_pwr) else $error("pwr");
	property p_rst_cause;
		$rose(softResetOut) |-> $past(spiSelect_b, 2) == 1'b0;
	endproperty
	a_rst_cause: assert property (p_rst_cause) else $error("reinit");
	property p_stb_pulse;
		extWrStb |=> !extWrStb;
	endproperty
	a_stb_pulse: assert property (p_stb_pulse) else $error("strobe");
	property p_ext_hold;
		!extWrStb |-> $stable({extAddr, extData, extLinkA, extLinkB});
	endproperty
	a_ext_hold: assert property (p_ext_hold) else $error("fwd hold");
	property p_oe_idle;
		spiSelect_b[*6] |-> sdioOe_b && sdoOe_b;
	endproperty
	a_oe_idle: assert property (p_oe_idle) else $error("idle drive");
	property p_one_line;
		!(!sdioOe_b && !sdoOe_b);
	endproperty
	a_one_line: assert property (p_one_line) else $error("two lines");
endmodule : dscp_regbank_props

bind dscp_regbank dscp_regbank_props chk_u (.clock(clock), .rst_b(rst_b),
	.spiSelect_b(spiSelect_b), .sdioOe_b(sdioOe_b), .sdoOe_b(sdoOe_b),
	.txGateA(txGateA), .txGateB(txGateB), .dualAGateMask(dualAGateMask),
	.dualBGateMask(dualBGateMask), .refOff(refOff), .chanOff(chanOff),
	.softResetOut(softResetOut), .extWrStb(extWrStb), .extAddr(extAddr),
	.extData(extData), .extLinkA(extLinkA), .extLinkB(extLinkB));

// [verif/dscp_host_model.sv]
// Host side of the serial port: frames bits on select, clock and data.
// Assumes the bench calls frame() one at a time.
`timescale 1ns/1ns
module dscp_host_model (
	input  wire logic clock,
	output logic      spiSelect_b,
	output logic      spiSclk,
	output wire logic sdioIn,
	input  wire logic sdioOut,
	input  wire logic sdioOe_b,
	input  wire logic sdoOut
);
	logic hostDrv = 0;
	logic hostBit = 0;
	logic lastBit = 0;
	// No pull on the line: released level keeps flipping
	assign sdioIn = !sdioOe_b ? sdioOut : (hostDrv ? hostBit : ~lastBit);
	always @(posedge clock) lastBit <= sdioIn;
	initial begin
		spiSelect_b = 1;
		spiSclk = 0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
	endtask : tick
	// Slow clock: six cycles low, five high, data held past the rise
	task automatic bitx(input logic v, input logic drv, input logic useSdo,
		output logic got);
		tick(1);
		spiSclk <= 0;
		hostDrv <= drv;
		hostBit <= v;
		tick(5);
		@(negedge clock);
		got = useSdo ? sdoOut : sdioIn;
		tick(1);
		spiSclk <= 1;
		tick(4);
	endtask : bitx
	task automatic frame(input logic rd, input logic [14:0] addr, input int n,
		input logic [15:0] wd, input logic lsb, input logic useSdo,
		output logic [15:0] rdata);
		logic [15:0] ins;
		logic        b;
		int          k;
		ins = {rd, addr};
		rdata = 0;
		tick(1);
		spiSelect_b <= 0;
		for (int i = 15; i >= 0; i--) bitx(ins[i], 1, useSdo, b);
		for (int i = 0; i < 8 * n; i++) begin
			k = 8 * (i / 8) + (lsb ? i % 8 : 7 - i % 8);
			bitx(wd[k], !rd, useSdo, b);
			rdata[k] = b;
		end
		tick(1);
		spiSclk <= 0;
		spiSelect_b <= 1;
		hostDrv <= 0;
		tick(8);
	endtask : frame
endmodule : dscp_host_model

// [verif/tb_dscp_regbank.sv]
// Bench for the config bank: host model frames, integer model compared.
// Assumes dscp_host_model; ce held high.
`timescale 1ns/1ns
module tb_dscp_regbank;
	import dscp_pkg::*;
	logic             clock = 0;
	logic             rst_b = 0;
	logic             gA = 1, gB = 1, mA = 0, mB = 0;
	wire logic        sel, sclk, sdi, sdo, sdoE, sOut, sOe, refO, sr, stb;
	wire logic        eLA, eLB;
	wire logic [3:0]  chOff;
	wire logic [14:0] eAddr;
	wire logic [7:0]  eData;
	int fails = 0, checkCount = 0, seed = 19, stbCount = 0, srCount = 0;
	int lsb = 0, up = 0, drv = 0, page = 3, pwr = 'hf8;
	int nExt, lastA, lastD, s;
	int adr[7] = '{0, 3, 4, 5, 8, 'h11, 'h200};
	always #4 clock = ~clock;
	always @(posedge clock) begin
		if (stb === 1'b1) stbCount++;
		if (sr === 1'b1) srCount++;
	end
	dscp_regbank dut_u (.clock(clock), .rst_b(rst_b), .ce(1'b1),
		.spiSelect_b(sel), .spiSclk(sclk), .sdioIn(sdi), .sdioOut(sdo),
		.sdioOe_b(sdoE), .sdoOut(sOut), .sdoOe_b(sOe), .txGateA(gA),
		.txGateB(gB), .dualAGateMask(mA), .dualBGateMask(mB), .refOff(refO),
		.chanOff(chOff), .softResetOut(sr), .extWrStb(stb), .extAddr(eAddr),
		.extData(eData), .extLinkA(eLA), .extLinkB(eLB));
	dscp_host_model host_u (.clock(clock), .spiSelect_b(sel), .spiSclk(sclk),
		.sdioIn(sdi), .sdioOut(sdo), .sdioOe_b(sdoE), .sdoOut(sOut));
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
	endtask : tick
	task automatic check(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		checkCount++;
		if (seen !== exp) begin
			fails++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	// Identity values are arbitrary design defaults
	function automatic logic [7:0] expRd(input int a);
		case (a)
			0: return {1'b0, lsb[0], up[0], drv[0], drv[0], up[0], lsb[0], 1'b0};
			3: return 8'h5a;
			4: return 8'hc3;
			5: return 8'h12;
			8: return page[7:0];
			'h11: return pwr[7:0];
			default: return 8'h00;
		endcase
	endfunction : expRd
	task automatic mwr(input int a, input int d);
		if (a == 0) begin
			lsb = d[1] & ~d[0];
			up = d[2] & ~d[0];
			drv = d[3] & ~d[0];
			if (d[0]) page = 3;
			if (d[0]) pwr = 'hf8;
		end else if (a == 8) page = d & 3;
		else if (a == 'h11) pwr = d & 'hf8;
		else if (a < 3 || a > 5) begin
			nExt++;
			lastA = a;
			lastD = d & 'hff;
		end
	endtask : mwr
	task automatic xfer(input logic rd, input int a, input int n,
		input logic [15:0] wd);
		logic [15:0] got;
		int          s0;
		s0 = stbCount;
		nExt = 0;
		host_u.frame(rd, a[14:0], n, wd, lsb[0], drv[0], got);
		for (int j = 0; j < n; j++) begin
			if (rd) check("read", got[8*j+:8], expRd(a));
			else mwr(a, wd[8*j+:8]);
			a = (up ? a + 1 : a - 1) & 'h7fff;
		end
		if (rd) return;
		tick(3);
		check("fwd count", stbCount - s0, nExt);
		if (nExt == 0) return;
		check("fwd addr", eAddr, lastA);
		check("fwd data", eData, lastD);
		check("links", {eLB, eLA}, page & 3);
	endtask : xfer
	task automatic pins();
		logic e;
		tick(6);
		check("refOff", refO, pwr[7]);
		for (int k = 0; k < 4; k++) begin
			e = pwr[6-k] | (k < 2 ? mA & ~gA : mB & ~gB);
			check("chanOff", chOff[k], e);
		end
	endtask : pins
	task automatic give_verdict();
		$display("Checks %0d mismatches %0d", checkCount, fails);
		if (fails == 0 && checkCount > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : give_verdict
	initial begin
		repeat (80000) @(posedge clock);
		fails++;
		give_verdict();
	end
	initial begin
		repeat (20) @(posedge clock);
		rst_b <= 1;
		tick(2);
		pins();
		foreach (adr[i]) xfer(1, adr[i], 1, 0);
		$display("Test reset done");
		for (int a = 3; a < 6; a++) begin
			xfer(0, a, 1, 16'($random(seed)));
			xfer(1, a, 1, 0);
		end
		$display("Test identity done");
		for (int p = 0; p < 4; p++) begin
			xfer(0, 8, 1, p);
			xfer(1, 8, 1, 0);
			xfer(0, 'h100 + p, 1, 16'($random(seed)));
		end
		$display("Test page done");
		repeat (8) begin
			@(posedge clock);
			{mA, mB, gA, gB} <= 4'($random(seed));
			xfer(0, 'h11, 1, 16'($random(seed)));
			xfer(1, 'h11, 1, 0);
			pins();
		end
		$display("Test power done");
		// Every order, direction and drive combination
		for (int m = 0; m < 8; m++) begin
			xfer(0, 0, 1, m << 1);
			xfer(1, 0, 1, 0);
			xfer(1, 4, 2, 0);
			xfer(0, 8, 2, 16'($random(seed)));
		end
		$display("Test modes done");
		s = srCount;
		xfer(0, 0, 1, 'h0b);
		tick(20);
		check("reinit cycles", srCount - s, 16);
		foreach (adr[i]) xfer(1, adr[i], 1, 0);
		pins();
		$display("Test reinit done");
		give_verdict();
	end
endmodule : tb_dscp_regbank
